// ---- rtl/otbr_pkg.sv ----
package otbr_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OTBR_OFS_CTRL = 8'h00;
  localparam logic [7:0] OTBR_OFS_OOK = 8'h04;
  localparam logic [7:0] OTBR_OFS_RATE = 8'h08;
  localparam logic [7:0] OTBR_OFS_STATUS = 8'h0C;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] OTBR_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] OTBR_OOK_RST = 32'h0000_0000;
  localparam logic [31:0] OTBR_RATE_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OTBR_CTRL_MODE_LSB = 0;
  localparam int OTBR_CTRL_DPM_LSB = 4;
  localparam int OTBR_CTRL_SYNC_DIS_BIT = 6;
  localparam int OTBR_CTRL_CLKOUT_BIT = 7;
  localparam int OTBR_CTRL_FSK_BIT = 8;
  localparam int OTBR_CTRL_FDEV_LSB = 16;
  localparam int OTBR_OOK_KIND_LSB = 0;
  localparam int OTBR_OOK_STEP_LSB = 4;
  localparam int OTBR_OOK_IVAL_LSB = 8;
  localparam int OTBR_OOK_CUT_LSB = 12;
  localparam int OTBR_RATE_BR_LSB = 0;
  localparam int OTBR_RATE_FLOOR_LSB = 8;

  // ----------------------------------------------------------------
  // Modes and encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OTBR_CHIP_SLEEP = 3'b000,
    OTBR_CHIP_STANDBY = 3'b001,
    OTBR_CHIP_SYNTH = 3'b010,
    OTBR_CHIP_RECEIVE = 3'b011,
    OTBR_CHIP_TRANSMIT = 3'b100
  } otbr_chip_mode_t;

  typedef enum logic [1:0] {
    OTBR_SYNC_IDLE = 2'b00,
    OTBR_SYNC_TRAIN = 2'b01,
    OTBR_SYNC_LOCKED = 2'b10
  } otbr_sync_state_t;

  localparam logic [1:0] OTBR_DPM_CONTINUOUS = 2'b00;
  localparam logic [1:0] OTBR_DPM_BUFFERED = 2'b01;
  localparam logic [1:0] OTBR_KIND_PEAK = 2'b00;
  localparam logic [1:0] OTBR_KIND_FIXED = 2'b01;
  localparam logic [1:0] OTBR_KIND_AVERAGE = 2'b10;

  // ----------------------------------------------------------------
  // Timing and scaling constants
  // ----------------------------------------------------------------
  // RSSI and thresholds are in 0.5 dB units; 6 dB backoff is 12 units
  localparam logic [7:0] OTBR_PEAK_BACKOFF = 8'h0C;
  // Crystal cycles per bit = 64 * (1 + divider); 16 sub-ticks per bit
  localparam int OTBR_BIT_CYCLE_SHIFT = 6;
  localparam int OTBR_SUB_CYCLE_SHIFT = 2;
  // Three preamble bytes of alternating bits give 24 transitions
  localparam logic [4:0] OTBR_PREAMBLE_EDGES = 5'h18;
  // Filter shifts for the average threshold (16 samples per bit)
  localparam logic [3:0] OTBR_AVG_SHIFT_00 = 4'h6;
  localparam logic [3:0] OTBR_AVG_SHIFT_01 = 4'h7;
  localparam logic [3:0] OTBR_AVG_SHIFT_1X = 4'h8;

endpackage : otbr_pkg

// ---- rtl/otbr_rate_div.sv ----
`timescale 1ns/1ps
`default_nettype none

module otbr_rate_div
  import otbr_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic enable,
  input wire logic [7:0] bit_rate_divider,
  // Enable pulse, sixteen per bit period
  output logic sub_tick
);

  // ----------------------------------------------------------------
  // Sixteenth-of-bit divider
  // ----------------------------------------------------------------
  logic [9:0] cnt_reg;
  logic [9:0] cnt_next;
  logic [9:0] last_count;
  logic sub_tick_next;

  // Period is 4 * (1 + divider) cycles, so 16 ticks give 64 * (1 + divider)
  assign last_count = 10'(({2'b00, bit_rate_divider} + 10'h001) << OTBR_SUB_CYCLE_SHIFT) - 10'h001;
  assign sub_tick_next = enable && (cnt_reg >= last_count);
  assign cnt_next = (!enable || sub_tick_next) ? 10'h000 : cnt_reg + 10'h001;

  // Counter held at zero while idle so the first tick is a full period away
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 10'h000;
      sub_tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      sub_tick <= sub_tick_next;
    end
  end

endmodule : otbr_rate_div

`default_nettype wire

// ---- rtl/otbr_rx.sv ----
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module otbr_rx
  import otbr_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive front end, same clock
  input wire logic [7:0] rssi_value,
  input wire logic fsk_raw_bit,
  // Second interrupt pin, two-way
  input wire logic irq1_in,
  output logic irq1_out,
  output logic irq1_oe,
  // Data pin
  output logic data_out,
  output logic data_oe,
  // Toward FIFO
  output logic fifo_bit,
  output logic fifo_bit_valid,
  // Operating mode enables
  output logic rx_path_enable,
  output logic synth_enable,
  output logic tx_enable,
  output logic clkout_enable
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Decrement interval in sixteenths of a chip
  function automatic logic [7:0] decay_limit(input logic [2:0] code);
    case (code)
      3'b000: decay_limit = 8'h10;
      3'b001: decay_limit = 8'h20;
      3'b010: decay_limit = 8'h40;
      3'b011: decay_limit = 8'h80;
      3'b100: decay_limit = 8'h08;
      3'b101: decay_limit = 8'h04;
      3'b110: decay_limit = 8'h02;
      default: decay_limit = 8'h01;
    endcase
  endfunction : decay_limit

  // Step size in 0.5 dB units
  function automatic logic [7:0] step_units(input logic [2:0] code);
    case (code)
      3'b000: step_units = 8'h01;
      3'b001: step_units = 8'h02;
      3'b010: step_units = 8'h03;
      3'b011: step_units = 8'h04;
      3'b100: step_units = 8'h06;
      3'b101: step_units = 8'h08;
      3'b110: step_units = 8'h0A;
      default: step_units = 8'h0C;
    endcase
  endfunction : step_units

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] ook_reg;
  logic [31:0] rate_reg;

  // Field views
  logic [2:0] chip_operating_mode;
  logic [1:0] data_path_mode;
  logic synchronizer_disable;
  logic clock_output_enable;
  logic fsk_select;
  logic [7:0] freq_deviation_setting;
  logic [1:0] threshold_kind_select;
  logic [2:0] peak_decay_step;
  logic [2:0] peak_decay_interval;
  logic [1:0] average_filter_cutoff;
  logic [7:0] bit_rate_divider;
  logic [7:0] threshold_floor_level;

  assign chip_operating_mode = ctrl_reg[OTBR_CTRL_MODE_LSB +: 3];
  assign data_path_mode = ctrl_reg[OTBR_CTRL_DPM_LSB +: 2];
  assign synchronizer_disable = ctrl_reg[OTBR_CTRL_SYNC_DIS_BIT];
  assign clock_output_enable = ctrl_reg[OTBR_CTRL_CLKOUT_BIT];
  assign fsk_select = ctrl_reg[OTBR_CTRL_FSK_BIT];
  // Deviation is only stored and read back; no logic or port uses it
  assign freq_deviation_setting = ctrl_reg[OTBR_CTRL_FDEV_LSB +: 8];
  assign threshold_kind_select = ook_reg[OTBR_OOK_KIND_LSB +: 2];
  assign peak_decay_step = ook_reg[OTBR_OOK_STEP_LSB +: 3];
  assign peak_decay_interval = ook_reg[OTBR_OOK_IVAL_LSB +: 3];
  assign average_filter_cutoff = ook_reg[OTBR_OOK_CUT_LSB +: 2];
  assign bit_rate_divider = rate_reg[OTBR_RATE_BR_LSB +: 8];
  assign threshold_floor_level = rate_reg[OTBR_RATE_FLOOR_LSB +: 8];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic sel_ctrl;
  logic sel_ook;
  logic sel_rate;
  logic sel_status;
  logic addr_hit;
  logic apb_access;
  logic apb_done;
  logic [31:0] status_word;
  logic [31:0] read_word;

  assign sel_ctrl = (paddr == OTBR_OFS_CTRL);
  assign sel_ook = (paddr == OTBR_OFS_OOK);
  assign sel_rate = (paddr == OTBR_OFS_RATE);
  assign sel_status = (paddr == OTBR_OFS_STATUS);
  assign addr_hit = sel_ctrl || sel_ook || sel_rate || sel_status;
  // One wait state: pready rises the cycle after the access phase starts
  assign apb_access = psel && penable && !pready;
  assign apb_done = psel && penable && pready;

  // Read mux; unmapped offsets read zero
  assign read_word = sel_ctrl ? ctrl_reg :
                     sel_ook ? ook_reg :
                     sel_rate ? rate_reg :
                     sel_status ? status_word : 32'h0000_0000;

  // Bus answer and read data, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access && !addr_hit;
      if (apb_access && !pwrite) begin
        prdata <= read_word;
      end
    end
  end

  // Writes land on the completing edge; status is read only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= OTBR_CTRL_RST;
      ook_reg <= OTBR_OOK_RST;
      rate_reg <= OTBR_RATE_RST;
    end else if (apb_done && pwrite) begin
      if (sel_ctrl) begin
        ctrl_reg <= pwdata;
      end else if (sel_ook) begin
        ook_reg <= pwdata;
      end else if (sel_rate) begin
        rate_reg <= pwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Chip mode and data path decode
  // ----------------------------------------------------------------
  otbr_chip_mode_t chip_mode;
  logic rx_next;
  logic synth_next;
  logic tx_next;
  logic awake_next;
  logic continuous_mode;

  assign chip_mode = otbr_chip_mode_t'(chip_operating_mode);
  assign continuous_mode = (data_path_mode == OTBR_DPM_CONTINUOUS);

  // Undefined codes behave as sleep so nothing runs by accident
  always_comb begin
    rx_next = 1'b0;
    synth_next = 1'b0;
    tx_next = 1'b0;
    awake_next = 1'b0;
    case (chip_mode)
      OTBR_CHIP_STANDBY: awake_next = 1'b1;
      OTBR_CHIP_SYNTH: begin
        awake_next = 1'b1;
        synth_next = 1'b1;
      end
      OTBR_CHIP_RECEIVE: begin
        awake_next = 1'b1;
        synth_next = 1'b1;
        rx_next = 1'b1;
      end
      OTBR_CHIP_TRANSMIT: begin
        awake_next = 1'b1;
        synth_next = 1'b1;
        tx_next = 1'b1;
      end
      default: awake_next = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_path_enable <= 1'b0;
      synth_enable <= 1'b0;
      tx_enable <= 1'b0;
      clkout_enable <= 1'b0;
    end else begin
      rx_path_enable <= rx_next;
      synth_enable <= synth_next;
      tx_enable <= tx_next;
      clkout_enable <= awake_next && clock_output_enable;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchroniser and rate divider
  // ----------------------------------------------------------------
  logic irq1_meta_reg;
  logic irq1_sync_reg;
  logic sub_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq1_meta_reg <= 1'b0;
      irq1_sync_reg <= 1'b0;
    end else begin
      irq1_meta_reg <= irq1_in;
      irq1_sync_reg <= irq1_meta_reg;
    end
  end

  otbr_rate_div u_rate_div (
    .pclk(pclk),
    .presetn(presetn),
    .enable(rx_path_enable),
    .bit_rate_divider(bit_rate_divider),
    .sub_tick(sub_tick)
  );

  // ----------------------------------------------------------------
  // OOK thresholds
  // ----------------------------------------------------------------
  logic [7:0] peak_reg;
  logic [7:0] peak_next;
  logic [15:0] avg_acc_reg;
  logic [7:0] decay_cnt_reg;
  logic ook_bit_reg;
  logic [8:0] peak_min9;
  logic [7:0] peak_min;
  logic [8:0] peak_dec9;
  logic [7:0] peak_decayed;
  logic [7:0] peak_less6;
  logic [7:0] peak_thresh;
  logic [7:0] threshold;
  logic [3:0] avg_shift;
  logic signed [16:0] avg_diff;
  logic signed [16:0] avg_delta;
  logic decay_tick;
  logic decay_allowed;
  logic peak_mode;

  assign peak_mode = (threshold_kind_select != OTBR_KIND_FIXED) &&
                     (threshold_kind_select != OTBR_KIND_AVERAGE);
  // Highest peak whose threshold still sits on the floor, saturated
  assign peak_min9 = {1'b0, threshold_floor_level} + {1'b0, OTBR_PEAK_BACKOFF};
  assign peak_min = peak_min9[8] ? 8'hFF : peak_min9[7:0];
  assign peak_dec9 = {1'b0, peak_reg} - {1'b0, step_units(peak_decay_step)};
  assign peak_decayed = (peak_dec9[8] || (peak_dec9[7:0] < peak_min)) ?
                        peak_min : peak_dec9[7:0];
  assign peak_less6 = (peak_reg > OTBR_PEAK_BACKOFF) ? peak_reg - OTBR_PEAK_BACKOFF : 8'h00;
  assign peak_thresh = (peak_less6 > threshold_floor_level) ?
                       peak_less6 : threshold_floor_level;

  // Decrement interval counted in sixteenths of a chip
  assign decay_tick = sub_tick && (decay_cnt_reg >= decay_limit(peak_decay_interval) - 8'h01);
  assign decay_allowed = decay_tick && !ook_bit_reg;

  always_comb begin
    if (rssi_value > peak_reg) begin
      peak_next = rssi_value;
    end else if (decay_allowed) begin
      peak_next = peak_decayed;
    end else begin
      peak_next = peak_reg;
    end
  end

  // One-pole filter, 16 samples a bit; larger shift gives lower cutoff
  assign avg_shift = (average_filter_cutoff == 2'b00) ? OTBR_AVG_SHIFT_00 :
                     (average_filter_cutoff == 2'b01) ? OTBR_AVG_SHIFT_01 :
                     OTBR_AVG_SHIFT_1X;
  assign avg_diff = $signed({1'b0, rssi_value, 8'h00}) - $signed({1'b0, avg_acc_reg});
  assign avg_delta = avg_diff >>> avg_shift;

  assign threshold = (threshold_kind_select == OTBR_KIND_FIXED) ? threshold_floor_level :
                     (threshold_kind_select == OTBR_KIND_AVERAGE) ? avg_acc_reg[15:8] :
                     peak_thresh;

  // Peak tracker, filter and comparator, idle outside receive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peak_reg <= 8'h00;
      avg_acc_reg <= 16'h0000;
      decay_cnt_reg <= 8'h00;
      ook_bit_reg <= 1'b0;
    end else if (!rx_path_enable || !peak_mode) begin
      peak_reg <= peak_min;
      decay_cnt_reg <= 8'h00;
      ook_bit_reg <= rx_path_enable && (rssi_value > threshold);
      if (rx_path_enable && sub_tick) begin
        avg_acc_reg <= avg_acc_reg + avg_delta[15:0];
      end
    end else begin
      peak_reg <= peak_next;
      ook_bit_reg <= rssi_value > threshold;
      if (decay_tick) begin
        decay_cnt_reg <= 8'h00;
      end else if (sub_tick) begin
        decay_cnt_reg <= decay_cnt_reg + 8'h01;
      end
      if (sub_tick) begin
        avg_acc_reg <= avg_acc_reg + avg_delta[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Bit synchroniser
  // ----------------------------------------------------------------
  otbr_sync_state_t sync_state_reg;
  otbr_sync_state_t sync_state_next;
  logic raw_bit;
  logic raw_prev_reg;
  logic [13:0] phase_reg;
  logic [14:0] bit_cycles;
  logic [13:0] phase_last;
  logic [13:0] phase_half;
  logic [4:0] edge_cnt_reg;
  logic recovered_bit_clock_reg;
  logic sync_bit_reg;
  logic sync_on;
  logic data_edge;
  logic centre;

  // Demodulator choice; raw FSK can bypass the synchroniser
  assign raw_bit = fsk_select ? fsk_raw_bit : ook_bit_reg;
  // Forced on outside continuous; else off only if bit set and pin low
  assign sync_on = rx_path_enable &&
                   (!continuous_mode || !(synchronizer_disable && !irq1_sync_reg));
  assign bit_cycles = 15'(({7'h00, bit_rate_divider} + 15'h0001) << OTBR_BIT_CYCLE_SHIFT);
  assign phase_last = 14'(bit_cycles - 15'h0001);
  assign phase_half = bit_cycles[14:1];
  assign data_edge = raw_bit != raw_prev_reg;
  assign centre = sync_on && (phase_reg == phase_half);

  // Lock sequence: count preamble transitions, then hold lock
  always_comb begin
    sync_state_next = sync_state_reg;
    case (sync_state_reg)
      OTBR_SYNC_IDLE: begin
        if (sync_on) begin
          sync_state_next = OTBR_SYNC_TRAIN;
        end
      end
      OTBR_SYNC_TRAIN: begin
        if (!sync_on) begin
          sync_state_next = OTBR_SYNC_IDLE;
        end else if (edge_cnt_reg >= OTBR_PREAMBLE_EDGES) begin
          sync_state_next = OTBR_SYNC_LOCKED;
        end
      end
      OTBR_SYNC_LOCKED: begin
        if (!sync_on) begin
          sync_state_next = OTBR_SYNC_IDLE;
        end
      end
      default: sync_state_next = OTBR_SYNC_IDLE;
    endcase
  end

  // Phase restarts on each transition so the clock rises mid-bit;
  // free-running between edges keeps lock over long runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_state_reg <= OTBR_SYNC_IDLE;
      raw_prev_reg <= 1'b0;
      phase_reg <= 14'h0000;
      edge_cnt_reg <= 5'h00;
      recovered_bit_clock_reg <= 1'b0;
      sync_bit_reg <= 1'b0;
    end else begin
      sync_state_reg <= sync_state_next;
      raw_prev_reg <= raw_bit;
      if (!sync_on || data_edge || phase_reg >= phase_last) begin
        phase_reg <= 14'h0000;
      end else begin
        phase_reg <= phase_reg + 14'h0001;
      end
      if (sync_state_reg != OTBR_SYNC_TRAIN) begin
        edge_cnt_reg <= 5'h00;
      end else if (data_edge) begin
        edge_cnt_reg <= edge_cnt_reg + 5'h01;
      end
      recovered_bit_clock_reg <= sync_on && (phase_reg >= phase_half);
      if (centre) begin
        sync_bit_reg <= raw_bit;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output routing
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out <= 1'b0;
      data_oe <= 1'b0;
      irq1_out <= 1'b0;
      irq1_oe <= 1'b0;
      fifo_bit <= 1'b0;
      fifo_bit_valid <= 1'b0;
    end else begin
      data_oe <= rx_path_enable && continuous_mode;
      data_out <= sync_on ? sync_bit_reg : raw_bit;
      // Released when disable bit is set so the host can hold it low
      irq1_oe <= rx_path_enable && continuous_mode && !synchronizer_disable;
      irq1_out <= recovered_bit_clock_reg;
      fifo_bit <= raw_bit;
      fifo_bit_valid <= centre && !continuous_mode &&
                        (sync_state_reg == OTBR_SYNC_LOCKED);
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  assign status_word = {12'h000, rx_path_enable, sync_on,
                        (sync_state_reg == OTBR_SYNC_LOCKED), ook_bit_reg,
                        peak_reg, threshold};

endmodule : otbr_rx

`default_nettype wire

// ---- sim/otbr_rx_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checks on the receive back end
// ------------------------------------------------------------
module otbr_rx_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Receive side
  input wire logic irq1_out,
  input wire logic irq1_oe,
  input wire logic data_oe,
  input wire logic fifo_bit_valid,
  input wire logic rx_path_enable,
  input wire logic tx_enable
);
  // One domain, so one clock and one disable for all
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("ready not one cycle into access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_bit_spacing: assert property (fifo_bit_valid |=> !fifo_bit_valid [*8])
    else $error("bits closer than a bit period");
  // The pin copy of the clock is one register behind the valid pulse
  chk_fifo_clock: assert property (fifo_bit_valid |=> $rose(irq1_out))
    else $error("fifo bit off the clock edge");
  // Only locked bits are guarded; a stray data edge may cut an unlocked clock
  chk_clock_high: assert property (fifo_bit_valid |=> irq1_out [*8])
    else $error("recovered clock high too short");
  chk_rx_off: assert property ($fell(rx_path_enable) |=> !irq1_oe && !data_oe)
    else $error("pins driven outside receive");
  chk_mode_excl: assert property (rx_path_enable |-> !tx_enable)
    else $error("receive and transmit together");
  chk_fifo_pin: assert property (fifo_bit_valid |-> !data_oe)
    else $error("data pin driven in buffered use");
endmodule : otbr_rx_checker

bind otbr_rx otbr_rx_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .irq1_out(irq1_out),
  .irq1_oe(irq1_oe), .data_oe(data_oe), .fifo_bit_valid(fifo_bit_valid),
  .rx_path_enable(rx_path_enable), .tx_enable(tx_enable));
`default_nettype wire

// ---- sim/otbr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Host controller on the data and clock pins
// ------------------------------------------------------------
module otbr_host_model (
  // Clock
  input wire logic pclk,
  // Device pins
  input wire logic irq1_out,
  input wire logic irq1_oe,
  input wire logic data_out,
  // Host side
  input wire logic hold_low,
  output logic irq1_pin,
  output logic [7:0] got
);
  logic pin_q;
  // Pull-up on the pin; the host only ever pulls it low
  assign irq1_pin = irq1_oe ? irq1_out : !hold_low;
  // Take the data pin on each rising clock edge seen on the pin
  always_ff @(posedge pclk) begin
    pin_q <= irq1_pin;
    if (irq1_oe && irq1_pin && !pin_q) got <= {got[6:0], data_out};
  end
endmodule : otbr_host_model
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
  import otbr_pkg::*;
;
  // ------------------------------------------------------------
  // Stimulus, design and host
  // ------------------------------------------------------------
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic fsk_raw_bit = '0, hold_low = '0, err, irq1_pin, irq1_out, irq1_oe;
  logic pready, pslverr, data_out, data_oe, fifo_bit, fifo_bit_valid, rxe, syne, txe, cke;
  logic [7:0] paddr = '0, rssi_value = '0, fgot = '0, got;
  logic [31:0] pwdata = '0, prdata, rd;
  int mismatches = 0, checked = 0;
  always #5 pclk = ~pclk;
  otbr_rx u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rssi_value(rssi_value), .fsk_raw_bit(fsk_raw_bit),
    .irq1_in(irq1_pin), .irq1_out(irq1_out), .irq1_oe(irq1_oe), .data_out(data_out),
    .data_oe(data_oe), .fifo_bit(fifo_bit), .fifo_bit_valid(fifo_bit_valid),
    .rx_path_enable(rxe), .synth_enable(syne), .tx_enable(txe), .clkout_enable(cke));
  otbr_host_model u_host (.pclk(pclk), .irq1_out(irq1_out), .irq1_oe(irq1_oe),
    .data_out(data_out), .hold_low(hold_low), .irq1_pin(irq1_pin), .got(got));
  // Stand-in for the FIFO: collect bits as they are handed over
  always @(posedge pclk) if (fifo_bit_valid) fgot <= {fgot[6:0], fifo_bit};
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    checked++;
    if (act !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h want %h", $time, act, exp);
    end
  endtask : chk
  // One transfer; waits on pready, never on a fixed count
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Bits go out most significant first, one 64-cycle bit each
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      fsk_raw_bit <= b[i];
      repeat (64) @(posedge pclk);
    end
  endtask : send
  task automatic stop_test();
    $display("checked %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // Watchdog well past the expected run of about 10k cycles
  initial begin
    #500_000;
    mismatches++;
    stop_test();
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 3; i++) begin
      apb(8'(4 * i), 1'b0, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
    end
    apb(8'h10, 1'b0, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    $display("reset and map done");
    // Codes above transmit must behave as sleep
    for (int m = 0; m < 16; m++) begin
      apb(OTBR_OFS_CTRL, 1'b1, 32'(m % 8) | (m < 8 ? 32'h0000_0080 : 32'h0000_0000));
      repeat (2) @(posedge pclk);
      chk({rxe, txe}, {m % 8 == 3, m % 8 == 4});
      chk(syne, m % 8 >= 2 && m % 8 <= 4);
      chk(cke, m % 8 >= 1 && m % 8 <= 4 && m < 8);
    end
    $display("chip modes done");
    apb(OTBR_OFS_RATE, 1'b1, 32'h0000_4000);
    apb(OTBR_OFS_OOK, 1'b1, 32'h0000_0001);
    apb(OTBR_OFS_CTRL, 1'b1, 32'h0003_0003);
    rssi_value <= 8'h50;
    repeat (4) @(posedge pclk);
    apb(OTBR_OFS_STATUS, 1'b0, 32'h0000_0000);
    chk({rd[16], rd[7:0]}, 9'h140);
    rssi_value <= 8'h30;
    repeat (4) @(posedge pclk);
    apb(OTBR_OFS_STATUS, 1'b0, 32'h0000_0000);
    chk(rd[16], 32'h0000_0000);
    $display("fixed threshold done");
    apb(OTBR_OFS_RATE, 1'b1, 32'h0000_1000);
    apb(OTBR_OFS_OOK, 1'b1, 32'h0000_0410);
    rssi_value <= 8'h80;
    repeat (8) @(posedge pclk);
    apb(OTBR_OFS_STATUS, 1'b0, 32'h0000_0000);
    chk(rd[15:0], 32'h0000_8074);
    rssi_value <= 8'h00;
    repeat (640) @(posedge pclk);
    apb(OTBR_OFS_STATUS, 1'b0, 32'h0000_0000);
    chk(rd[15:8] >= 8'h56 && rd[15:8] <= 8'h5A, 32'h0000_0001);
    apb(OTBR_OFS_OOK, 1'b1, 32'h0000_0770);
    repeat (400) @(posedge pclk);
    apb(OTBR_OFS_STATUS, 1'b0, 32'h0000_0000);
    chk(rd[15:0], 32'h0000_1C10);
    $display("peak threshold done");
    // Average settles on a steady level; truncation may leave it one unit low
    apb(OTBR_OFS_OOK, 1'b1, 32'h0000_0002);
    rssi_value <= 8'h40;
    repeat (2500) @(posedge pclk);
    apb(OTBR_OFS_STATUS, 1'b0, 32'h0000_0000);
    chk(rd[7:0] >= 8'h3F && rd[7:0] <= 8'h40, 32'h0000_0001);
    $display("average threshold done");
    apb(OTBR_OFS_RATE, 1'b1, 32'h0000_0000);
    apb(OTBR_OFS_CTRL, 1'b1, 32'h0003_0103);
    repeat (4) send(8'h55);
    send(8'hC3);
    chk({irq1_oe, got}, 9'h1C3);
    send(8'h00);
    send(8'hF0);
    apb(OTBR_OFS_STATUS, 1'b0, 32'h0000_0000);
    chk({rd[17], got}, 9'h1F0);
    $display("continuous sync done");
    hold_low <= 1'b1;
    apb(OTBR_OFS_CTRL, 1'b1, 32'h0003_0143);
    repeat (4) @(posedge pclk);
    apb(OTBR_OFS_STATUS, 1'b0, 32'h0000_0000);
    chk({rd[18], irq1_oe}, 32'h0000_0000);
    fsk_raw_bit <= ~fsk_raw_bit;
    repeat (3) @(posedge pclk);
    chk({data_oe, data_out}, {1'b1, fsk_raw_bit});
    hold_low <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(OTBR_OFS_STATUS, 1'b0, 32'h0000_0000);
    chk(rd[18], 32'h0000_0001);
    $display("sync off done");
    hold_low <= 1'b1;
    apb(OTBR_OFS_CTRL, 1'b1, 32'h0003_0153);
    repeat (4) send(8'h55);
    send(8'h96);
    chk({data_oe, fgot}, 9'h096);
    apb(OTBR_OFS_CTRL, 1'b1, 32'h0003_0163);
    send(8'h3C);
    chk({data_oe, fgot}, 9'h03C);
    $display("buffered and packet done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
